// ==== rtl/pcs_cfg.svh ====
// Constants for the program counter sequencer: widths, vectors and timing counts.
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH

`define PCS_INSTR_W 13
`define PCS_PC_W_SMALL 9
`define PCS_PC_W_LARGE 11
`define PCS_RESET_VEC_SMALL 11'h1ff
`define PCS_RESET_VEC_LARGE 11'h7ff
`define PCS_HW_INT_VEC 11'h008
`define PCS_SW_INT_VEC 11'h002
`define PCS_NEAR_W 10
`define PCS_PAGE_BIT 2
`define PCS_PCHB_W 3
`define PCS_PCHB_RESET 3'h0
`define PCS_STACK_DEPTH 5
`define PCS_ICYC_DIV 2

`endif

// ==== rtl/pcs_pkg.sv ====
// Types shared by the program counter sequencer.
package pcs_pkg;

	// Program-flow class of the instruction now executing, from the core decoder.
	typedef enum logic [2:0]
	{
		PCS_OP_SEQ,
		PCS_OP_NEAR_JUMP,
		PCS_OP_NEAR_CALL,
		PCS_OP_FAR_JUMP,
		PCS_OP_FAR_CALL,
		PCS_OP_RETURN,
		PCS_OP_PAGE,
		PCS_OP_SW_INT
	} pcs_op_t;

endpackage : pcs_pkg

// ==== rtl/pcs_sequencer.sv ====
// Program counter, paging, return stack and fetch sequencing of the core.
`timescale 1ns/1ps
`include "pcs_cfg.svh"

module pcs_sequencer #(
	parameter int LARGE = 1, // 1 selects the 2K-word variant, 0 the 512-word one.
	parameter int ICYC_DIV = `PCS_ICYC_DIV, // System clocks per instruction cycle.
	parameter int PC_W = (LARGE != 0) ? `PCS_PC_W_LARGE : `PCS_PC_W_SMALL // Program counter width.
) (
	input wire logic i_sys_clk, // System clock.
	input wire logic i_rst_n, // Synchronous core reset, active low.
	input wire logic i_external_clear_n, // External clear pin, active low.
	input wire logic [`PCS_INSTR_W-1:0] i_instr, // Word read from program memory at o_prog_addr.
	input wire pcs_pkg::pcs_op_t i_op, // Flow class of o_instr, sampled while o_icyc_en is high.
	input wire logic i_pc_high_buffer_wr, // Software write strobe for the page buffer.
	input wire logic [`PCS_PCHB_W-1:0] i_pc_high_buffer_wdata, // Software write data for the page buffer.
	input wire logic i_timer_overflow, // Timer overflow pulse, same clock.
	input wire logic i_ext_int, // External interrupt pin, asynchronous.
	input wire logic i_int_enable, // Global interrupt enable from the core.
	input wire logic i_rc_osc_mode, // High when the RC oscillator option is chosen.
	output logic [PC_W-1:0] o_prog_addr, // Program memory fetch address.
	output logic [`PCS_INSTR_W-1:0] o_instr, // Instruction handed to the core.
	output logic o_instr_valid, // High for one cycle after each word loads into o_instr, discarded words included.
	output logic o_icyc_en, // One-cycle pulse per instruction cycle.
	output logic [`PCS_PCHB_W-1:0] o_pc_high_buffer, // Page buffer contents.
	output logic o_int_taken, // Pulse when an interrupt is accepted.
	output logic o_osc_out // Oscillator output pin.
);
	import pcs_pkg::*;

	localparam logic [PC_W-1:0] RST_VEC = (LARGE != 0) ? PC_W'(`PCS_RESET_VEC_LARGE) :
		PC_W'(`PCS_RESET_VEC_SMALL);
	localparam logic [PC_W-1:0] HW_VEC = PC_W'(`PCS_HW_INT_VEC);
	localparam logic [PC_W-1:0] SW_VEC = PC_W'(`PCS_SW_INT_VEC);
	localparam int DEPTH = `PCS_STACK_DEPTH;
	localparam logic [2:0] SP_LAST = 3'(`PCS_STACK_DEPTH - 1);
	localparam logic [7:0] DIV_LAST = 8'(ICYC_DIV - 1);

	logic clr_s1_reg;
	logic clr_s2_reg;
	logic int_s1_reg;
	logic int_s2_reg;
	logic int_s3_reg;
	logic rst;
	logic [7:0] div_reg;
	logic [PC_W-1:0] pc_reg;
	logic [PC_W-1:0] pc_next;
	logic flush_reg;
	logic pend_reg;
	logic take_int;
	logic is_branch;
	logic do_push;
	logic do_pop;
	logic [PC_W-1:0] stack_reg [DEPTH];
	logic [2:0] sp_reg;
	logic [2:0] sp_top;
	logic [PC_W-1:0] near_tgt;
	logic [PC_W-1:0] far_tgt;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and reset.

	// Both pins are asynchronous, so each passes two flops before any logic.
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			clr_s1_reg <= 1'b1;
			clr_s2_reg <= 1'b1;
			int_s1_reg <= 1'b0;
			int_s2_reg <= 1'b0;
			int_s3_reg <= 1'b0;
		end
		else
		begin
			clr_s1_reg <= i_external_clear_n;
			clr_s2_reg <= clr_s1_reg;
			int_s1_reg <= i_ext_int;
			int_s2_reg <= int_s1_reg;
			int_s3_reg <= int_s2_reg;
		end
	end

	// The clear pin holds everything below in reset while it is low.
	assign rst = !i_rst_n || !clr_s2_reg;

	////////////////////////////////////////////////////////////////////////////
	// Instruction cycle divider and oscillator output.

	// One enable pulse per instruction cycle; every sequencing step waits for it.
	always_ff @(posedge i_sys_clk)
	begin
		if (rst)
		begin
			div_reg <= 8'h00;
			o_icyc_en <= 1'b0;
		end
		else
		begin
			o_icyc_en <= (div_reg == DIV_LAST);
			div_reg <= (div_reg == DIV_LAST) ? 8'h00 : div_reg + 8'h01;
		end
	end

	// The output only toggles in RC mode; the pin is driven low otherwise.
	always_ff @(posedge i_sys_clk)
	begin
		if (rst)
			o_osc_out <= 1'b0;
		else if (!i_rc_osc_mode)
			o_osc_out <= 1'b0;
		else if (o_icyc_en)
			o_osc_out <= !o_osc_out;
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt capture.

	// A new event in the acceptance cycle keeps the flag set, so none is lost.
	always_ff @(posedge i_sys_clk)
	begin
		if (rst)
			pend_reg <= 1'b0;
		else if (i_timer_overflow || (int_s2_reg && !int_s3_reg))
			pend_reg <= 1'b1;
		else if (take_int)
			pend_reg <= 1'b0;
	end

	// Interrupts are taken only beside a plain instruction, never during a bubble.
	assign is_branch = (i_op != PCS_OP_SEQ) && (i_op != PCS_OP_PAGE);
	assign take_int = o_icyc_en && !flush_reg && pend_reg && i_int_enable && !is_branch;

	always_ff @(posedge i_sys_clk)
	begin
		if (rst)
			o_int_taken <= 1'b0;
		else
			o_int_taken <= take_int;
	end

	////////////////////////////////////////////////////////////////////////////
	// Page buffer.

	// A software write wins over a page-select executed in the same cycle.
	always_ff @(posedge i_sys_clk)
	begin
		if (rst)
			o_pc_high_buffer <= `PCS_PCHB_RESET;
		else if (i_pc_high_buffer_wr)
			o_pc_high_buffer <= i_pc_high_buffer_wdata;
		else if (o_icyc_en && !flush_reg && i_op == PCS_OP_PAGE)
			o_pc_high_buffer[`PCS_PAGE_BIT] <= o_instr[0];
	end

	////////////////////////////////////////////////////////////////////////////
	// Branch targets.

	// Near targets stay inside one 1K page; the large part adds the page bit.
	generate
		if (LARGE != 0)
		begin : g_large
			assign near_tgt = {o_pc_high_buffer[`PCS_PAGE_BIT], o_instr[`PCS_NEAR_W-1:0]};
		end
		else
		begin : g_small
			assign near_tgt = o_instr[PC_W-1:0];
		end
	endgenerate

	// Far forms carry the full width and ignore the page bit.
	assign far_tgt = o_instr[PC_W-1:0];

	////////////////////////////////////////////////////////////////////////////
	// Program counter.

	// pc_reg always names the word being fetched, which is the next instruction.
	always_comb
	begin
		pc_next = pc_reg + PC_W'(1);
		do_push = 1'b0;
		do_pop = 1'b0;
		if (!flush_reg)
		begin
			if (take_int)
			begin
				pc_next = HW_VEC;
				do_push = 1'b1;
			end
			else
			begin
				unique case (i_op)
					PCS_OP_SEQ, PCS_OP_PAGE: pc_next = pc_reg + PC_W'(1);
					PCS_OP_NEAR_JUMP: pc_next = near_tgt;
					PCS_OP_FAR_JUMP: pc_next = far_tgt;
					PCS_OP_NEAR_CALL:
					begin
						pc_next = near_tgt;
						do_push = 1'b1;
					end
					PCS_OP_FAR_CALL:
					begin
						pc_next = far_tgt;
						do_push = 1'b1;
					end
					PCS_OP_SW_INT:
					begin
						pc_next = SW_VEC;
						do_push = 1'b1;
					end
					PCS_OP_RETURN:
					begin
						pc_next = stack_reg[sp_top];
						do_pop = 1'b1;
					end
				endcase
			end
		end
	end

	// A redirect discards the word already fetched, so a branch costs a bubble.
	always_ff @(posedge i_sys_clk)
	begin
		if (rst)
		begin
			pc_reg <= RST_VEC;
			flush_reg <= 1'b1;
			o_instr <= '0;
			o_instr_valid <= 1'b0;
		end
		else if (o_icyc_en)
		begin
			pc_reg <= pc_next;
			flush_reg <= !flush_reg && (take_int || is_branch);
			o_instr <= i_instr;
			o_instr_valid <= 1'b1;
		end
		else
		begin
			o_instr_valid <= 1'b0;
		end
	end

	assign o_prog_addr = pc_reg;

	////////////////////////////////////////////////////////////////////////////
	// Return stack.

	// The stack wraps like a ring; a sixth push overwrites the oldest entry.
	assign sp_top = (sp_reg == 3'h0) ? SP_LAST : sp_reg - 3'h1;

	always_ff @(posedge i_sys_clk)
	begin
		if (rst)
			sp_reg <= 3'h0;
		else if (o_icyc_en && do_push)
			sp_reg <= (sp_reg == SP_LAST) ? 3'h0 : sp_reg + 3'h1;
		else if (o_icyc_en && do_pop)
			sp_reg <= sp_top;
	end

	// Entries are full program-counter width, so a return needs no paging.
	generate
		for (genvar i = 0; i < DEPTH; i++)
		begin : g_stack
			always_ff @(posedge i_sys_clk)
			begin
				if (rst)
					stack_reg[i] <= '0;
				else if (o_icyc_en && do_push && sp_reg == 3'(i))
					stack_reg[i] <= pc_reg;
			end
		end
	endgenerate

endmodule : pcs_sequencer

// ==== bench/pcs_sequencer_properties.sv ====
// Port checks for the program counter sequencer, either variant, two clocks per instruction cycle.
`timescale 1ns/1ps
module pcs_sequencer_properties #(
	parameter int PC_W = 11 // Counter width.
) (
	input wire logic i_sys_clk, // Clock.
	input wire logic i_rst_n, // Reset.
	input wire logic i_external_clear_n, // Clear pin.
	input wire pcs_pkg::pcs_op_t i_op, // Flow class.
	input wire logic i_pc_high_buffer_wr, // Page write.
	input wire logic [2:0] i_pc_high_buffer_wdata, // Page data.
	input wire logic i_rc_osc_mode, // RC mode.
	input wire logic [PC_W-1:0] o_prog_addr, // Fetch address.
	input wire logic [12:0] o_instr, // Word.
	input wire logic o_instr_valid, // Valid.
	input wire logic o_icyc_en, // Cycle pulse.
	input wire logic [2:0] o_pc_high_buffer, // Page buffer.
	input wire logic o_int_taken, // Accepted.
	input wire logic o_osc_out // Osc pin.
);
	import pcs_pkg::*;
	localparam logic [PC_W-1:0] RST = '1;
	logic bub_reg;
	// Marks a discarded slot; the design hides its flush, so it is rebuilt here.
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n || !i_external_clear_n)
			bub_reg <= 1'b1;
		else if (o_icyc_en)
			bub_reg <= !bub_reg && !(i_op inside {PCS_OP_SEQ, PCS_OP_PAGE});
		else if (o_int_taken)
			bub_reg <= 1'b1;
	end
	wire logic live = o_icyc_en && !bub_reg;
	////////////////////////
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n || !i_external_clear_n);
	AST_ICYC: assert property (o_icyc_en |=> !o_icyc_en ##1 o_icyc_en)
		else $error("cycle pulse spacing wrong");
	AST_VALID: assert property (o_icyc_en |=> o_instr_valid ##1 !o_instr_valid)
		else $error("valid pulse wrong");
	AST_RST: assert property ($rose(i_rst_n) |-> o_prog_addr == RST)
		else $error("reset vector wrong");
	// Cutting to the counter width leaves the plain 9-bit field on the small part.
	AST_NEAR: assert property (live && i_op inside {PCS_OP_NEAR_JUMP, PCS_OP_NEAR_CALL}
		|=> o_prog_addr == PC_W'({$past(o_pc_high_buffer[2]), $past(o_instr[9:0])}))
		else $error("near target wrong");
	AST_FAR: assert property (live && i_op inside {PCS_OP_FAR_JUMP, PCS_OP_FAR_CALL}
		|=> o_prog_addr == $past(o_instr[PC_W-1:0])) else $error("far target wrong");
	AST_SEQ: assert property ((o_icyc_en && (bub_reg || i_op inside {PCS_OP_SEQ, PCS_OP_PAGE}))
		##1 !o_int_taken |-> o_prog_addr == $past(o_prog_addr) + 1'b1) else $error("increment wrong");
	AST_INT: assert property (o_int_taken |-> o_prog_addr == 11'h008 && $past(i_op) == PCS_OP_SEQ)
		else $error("interrupt entry wrong");
	AST_SWI: assert property (live && i_op == PCS_OP_SW_INT |=> o_prog_addr == 11'h002)
		else $error("soft interrupt vector wrong");
	AST_PAGE: assert property (live && i_op == PCS_OP_PAGE && !i_pc_high_buffer_wr
		|=> o_pc_high_buffer[2] == $past(o_instr[0])) else $error("page select wrong");
	AST_PBWR: assert property (i_pc_high_buffer_wr |=> o_pc_high_buffer == $past(i_pc_high_buffer_wdata))
		else $error("page buffer write lost");
	AST_OSC: assert property (o_icyc_en && i_rc_osc_mode |=> o_osc_out != $past(o_osc_out))
		else $error("osc pin not toggling");
	// Main flows worth seeing.
	cover property (live && i_op == PCS_OP_NEAR_CALL);
	cover property (live && i_op == PCS_OP_RETURN);
	cover property (o_int_taken);
endmodule : pcs_sequencer_properties
bind pcs_sequencer pcs_sequencer_properties #(.PC_W(PC_W)) u_props (.i_sys_clk, .i_rst_n, .i_external_clear_n,
	.i_op, .i_pc_high_buffer_wr, .i_pc_high_buffer_wdata, .i_rc_osc_mode, .o_prog_addr, .o_instr,
	.o_instr_valid, .o_icyc_en,
	.o_pc_high_buffer, .o_int_taken, .o_osc_out);

// ==== bench/pcs_sequencer_tb.sv ====
// Bench for the program counter sequencer: a flow model notes each word due.
`timescale 1ns/1ps
module pcs_sequencer_tb;
	import pcs_pkg::*;
	logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_external_clear_n = 1'b1, i_pc_high_buffer_wr = 1'b0;
	logic i_timer_overflow = 1'b0, i_ext_int = 1'b0, i_int_enable = 1'b0, i_rc_osc_mode = 1'b1;
	logic [2:0] i_pc_high_buffer_wdata = 3'h0, pb = 3'h0;
	pcs_op_t i_op = PCS_OP_SEQ, op;
	pcs_op_t prog [$];
	logic [12:0] mem [2048], q [$], cw = 13'h0, nw;
	logic [10:0] rpc = 11'h7ff, stk [5];
	logic bub = 1'b1, pend = 1'b0, acc, psh, pop;
	logic [31:0] seed = 32'h30;
	int sp = 0, fail_count = 0, n_tests = 0;
	wire logic [10:0] o_prog_addr;
	wire logic [12:0] o_instr;
	wire logic [2:0] o_pc_high_buffer;
	wire logic o_instr_valid, o_icyc_en, o_int_taken, o_osc_out;
	wire logic [12:0] i_instr = mem[o_prog_addr];
	pcs_sequencer #(.LARGE(1)) dut (.i_sys_clk, .i_rst_n, .i_external_clear_n, .i_instr, .i_op,
		.i_pc_high_buffer_wr, .i_pc_high_buffer_wdata, .i_timer_overflow, .i_ext_int, .i_int_enable,
		.i_rc_osc_mode, .o_prog_addr, .o_instr,
		.o_instr_valid, .o_icyc_en, .o_pc_high_buffer, .o_int_taken, .o_osc_out);
	// The 512-word part runs the same flow in lockstep; the bound checker watches its reset vector and wrap.
	wire logic [8:0] s_prog_addr;
	wire logic [12:0] s_instr = mem[s_prog_addr];
	pcs_sequencer #(.LARGE(0)) dut_small (.i_sys_clk, .i_rst_n, .i_external_clear_n, .i_instr(s_instr), .i_op,
		.i_pc_high_buffer_wr, .i_pc_high_buffer_wdata, .i_timer_overflow, .i_ext_int, .i_int_enable,
		.i_rc_osc_mode, .o_prog_addr(s_prog_addr), .o_instr(), .o_instr_valid(), .o_icyc_en(),
		.o_pc_high_buffer(), .o_int_taken(), .o_osc_out());
	always #5 i_sys_clk = ~i_sys_clk;
	////////////////////////
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic step();
		@(posedge i_sys_clk);
		#1;
	endtask : step
	task automatic run(int n);
		repeat (n) step();
	endtask : run
	// Stop in a cycle with no instruction edge, so the model never races the main sequence.
	task automatic idle();
		step();
		while (o_icyc_en !== 1'b0) step();
	endtask : idle
	task automatic tally_and_finish();
		if (fail_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish
	// Flow model: picks the op, notes the word latched now, moves the expected counter.
	always @(posedge i_sys_clk)
	begin
		#1;
		if (o_icyc_en === 1'b1)
		begin
			op = (bub || !prog.size()) ? PCS_OP_SEQ : prog.pop_front();
			i_op = bub ? pcs_op_t'(xs() % 8) : op;
			acc = !bub && op inside {PCS_OP_SEQ, PCS_OP_PAGE} && pend && i_int_enable;
			psh = acc || !bub && op inside {PCS_OP_NEAR_CALL, PCS_OP_FAR_CALL, PCS_OP_SW_INT};
			pop = !bub && op == PCS_OP_RETURN;
			if (!bub && op == PCS_OP_PAGE)
				pb[2] = cw[0];
			if (psh)
				stk[sp] = rpc;
			sp = (sp + (psh ? 1 : pop ? 4 : 0)) % 5;
			nw = mem[rpc];
			q.push_back(nw);
			case (op)
				PCS_OP_NEAR_JUMP, PCS_OP_NEAR_CALL: rpc = {pb[2], cw[9:0]};
				PCS_OP_FAR_JUMP, PCS_OP_FAR_CALL: rpc = cw[10:0];
				PCS_OP_RETURN: rpc = stk[sp];
				PCS_OP_SW_INT: rpc = 11'h002;
				default: rpc = acc ? 11'h008 : rpc + 11'h1;
			endcase
			bub = !bub && (acc || !(op inside {PCS_OP_SEQ, PCS_OP_PAGE}));
			pend = pend && !acc;
			cw = nw;
		end
	end
	// Each valid word must be the oldest noted one.
	always @(posedge i_sys_clk)
	begin
		if (o_instr_valid === 1'b1)
		begin
			n_tests++;
			if (q.size() == 0 || o_instr !== q.pop_front())
			begin
				$display("[FAIL] %0t fetched word mismatch", $time);
				fail_count++;
			end
		end
	end
	initial
	begin
		#100000;
		fail_count++;
		tally_and_finish();
	end
	initial
	begin
		for (int i = 0; i < 2048; i++)
			mem[i] = 13'(xs());
		run(2);
		i_rst_n = 1'b1;
		run(6);
		idle();
		i_pc_high_buffer_wr = 1'b1;
		i_pc_high_buffer_wdata = 3'(xs());
		pb = i_pc_high_buffer_wdata;
		step();
		i_pc_high_buffer_wr = 1'b0;
		idle();
		// Back-to-back branches, a full five-deep call nest and its unwinding.
		prog = '{PCS_OP_PAGE, PCS_OP_NEAR_JUMP, PCS_OP_NEAR_CALL, PCS_OP_FAR_CALL, PCS_OP_NEAR_CALL,
			PCS_OP_PAGE, PCS_OP_FAR_CALL, PCS_OP_NEAR_CALL, PCS_OP_RETURN, PCS_OP_RETURN, PCS_OP_RETURN,
			PCS_OP_RETURN, PCS_OP_RETURN, PCS_OP_FAR_JUMP};
		while (prog.size()) step();
		// Timer then pin source, refused under branches, taken on a plain op.
		for (int k = 0; k < 2; k++)
		begin
			idle();
			i_int_enable = 1'b0;
			i_timer_overflow = (k == 0);
			i_ext_int = (k == 1);
			run(8);
			i_timer_overflow = 1'b0;
			idle();
			pend = 1'b1;
			i_int_enable = 1'b1;
			prog = '{PCS_OP_NEAR_JUMP, PCS_OP_FAR_JUMP, PCS_OP_SEQ, PCS_OP_RETURN};
			while (prog.size()) step();
		end
		idle();
		prog = '{PCS_OP_SW_INT};
		run(8);
		idle();
		i_rc_osc_mode = 1'b0;
		i_external_clear_n = 1'b0;
		run(4);
		i_external_clear_n = 1'b1;
		q.delete();
		rpc = 11'h7ff;
		bub = 1'b1;
		pb = 3'h0;
		sp = 0;
		run(12);
		tally_and_finish();
	end
endmodule : pcs_sequencer_tb
